// File: shared/mitv_pkg.sv
// mitv_pkg: vectors, priorities, mode codes and address limits of the interrupt/trap vectoring block
// assumes: included before all logic files
package mitv_pkg;
  // ==========================================================================
  // vectors (high byte address of each pair)
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFEE;
  localparam logic [15:0] VEC_NMI = 16'hFFFC;
  localparam logic [15:0] VEC_SOFT = 16'hFFFA;
  localparam logic [15:0] VEC_REQ1 = 16'hFFF8;
  localparam logic [15:0] VEC_CAPTURE = 16'hFFF6;
  localparam logic [15:0] VEC_COMPARE = 16'hFFF4;
  localparam logic [15:0] VEC_OVERFLOW = 16'hFFF2;
  localparam logic [15:0] VEC_T2MATCH = 16'hFFEC;
  localparam logic [15:0] VEC_REQ2 = 16'hFFEA;
  localparam logic [15:0] VEC_SERIAL = 16'hFFF0;
  // ==========================================================================
  // source index, highest priority first
  localparam int NSRC = 11;
  localparam logic [3:0] SRC_RESET = 4'h0;
  localparam logic [3:0] SRC_TRAP = 4'h1;
  localparam logic [3:0] SRC_NMI = 4'h2;
  localparam logic [3:0] SRC_SOFT = 4'h3;
  localparam logic [3:0] SRC_REQ1 = 4'h4;
  localparam logic [3:0] SRC_CAPTURE = 4'h5;
  localparam logic [3:0] SRC_COMPARE = 4'h6;
  localparam logic [3:0] SRC_OVERFLOW = 4'h7;
  localparam logic [3:0] SRC_T2MATCH = 4'h8;
  localparam logic [3:0] SRC_REQ2 = 4'h9;
  localparam logic [3:0] SRC_SERIAL = 4'hA;
  localparam logic [NSRC-1:0] NONMASKABLE = 11'h00F;
  // ==========================================================================
  // mode codes {mode_pin_high, mode_pin_low}
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  // ==========================================================================
  // undefined address ranges
  localparam logic [15:0] UNDEF_EXP_HI = 16'h0027;
  localparam logic [15:0] UNDEF_SC_HI = 16'h003F;
  localparam logic [15:0] UNDEF_SC2_LO = 16'h0140;
  localparam logic [15:0] UNDEF_SC2_HI = 16'hBFFF;

  typedef enum logic [2:0] {ST_RUN, ST_STACK, ST_MASK, ST_FETCH, ST_BRANCH} mitv_state_e;
endpackage : mitv_pkg

// File: shared/mitv_req_if.sv
// mitv_req_if: pending-request bundle between collector and sequencer
// assumes: one clock domain
`timescale 1ns/1ns
`default_nettype none
interface mitv_req_if;
  logic [mitv_pkg::NSRC-1:0] pend;
  logic [mitv_pkg::NSRC-1:0] clr;
  modport collector (output pend, input clr);
  modport sequencer (input pend, output clr);
endinterface : mitv_req_if
`default_nettype wire

// File: logic/mitv_collect.sv
// mitv_collect: gathers request sources into pending bits
// assumes: inputs synchronous to CLOCK, clear from the sequencer
`timescale 1ns/1ns
`default_nettype none
module mitv_collect (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // sources
  input wire logic nmi_n,
  input wire logic ext_request_one_n,
  input wire logic ext_request_two_n,
  input wire logic parallel_strobe_flag,
  input wire logic soft_interrupt_instr,
  input wire logic trap_event,
  input wire logic capture_request,
  input wire logic [1:0] compare_request,
  input wire logic overflow_request,
  input wire logic timer_two_match_request,
  input wire logic serial_request,
  // to sequencer
  mitv_req_if.collector req
);
  typedef struct packed {
    logic nmi_d;
    logic nmi_pend;
    logic soft_pend;
    logic trap_pend;
  } mitv_col_s;
  mitv_col_s s_reg, s_next;
  logic internal_merged_request;

  // ==========================================================================
  // merged internal line
  assign internal_merged_request = capture_request | (|compare_request) | overflow_request
    | timer_two_match_request | serial_request;

  always_comb begin
    s_next = s_reg;
    s_next.nmi_d = nmi_n;
    if (req.clr[mitv_pkg::SRC_NMI]) s_next.nmi_pend = 1'b0;
    if (s_reg.nmi_d && !nmi_n) s_next.nmi_pend = 1'b1;
    if (req.clr[mitv_pkg::SRC_SOFT]) s_next.soft_pend = 1'b0;
    if (soft_interrupt_instr) s_next.soft_pend = 1'b1;
    if (req.clr[mitv_pkg::SRC_TRAP]) s_next.trap_pend = 1'b0;
    if (trap_event) s_next.trap_pend = 1'b1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{nmi_d: 1'b1, nmi_pend: 1'b0, soft_pend: 1'b0, trap_pend: 1'b0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // latched trap, nmi and soft bits, levels for the rest; shared vectors
  always_comb begin
    req.pend = '0;
    req.pend[mitv_pkg::SRC_TRAP] = s_reg.trap_pend;
    req.pend[mitv_pkg::SRC_NMI] = s_reg.nmi_pend;
    req.pend[mitv_pkg::SRC_SOFT] = s_reg.soft_pend;
    req.pend[mitv_pkg::SRC_REQ1] = !ext_request_one_n | parallel_strobe_flag;
    req.pend[mitv_pkg::SRC_CAPTURE] = capture_request;
    req.pend[mitv_pkg::SRC_COMPARE] = |compare_request;
    req.pend[mitv_pkg::SRC_OVERFLOW] = overflow_request;
    req.pend[mitv_pkg::SRC_T2MATCH] = timer_two_match_request;
    req.pend[mitv_pkg::SRC_REQ2] = !ext_request_two_n;
    req.pend[mitv_pkg::SRC_SERIAL] = serial_request & internal_merged_request;
  end

  nmi_edge_a: assert property (@(posedge clock) disable iff (!rstn)
    ce && s_reg.nmi_d && !nmi_n |=> s_reg.nmi_pend)
    else $error("nmi edge lost");
endmodule : mitv_collect
`default_nettype wire

// File: logic/mitv_top.sv
// mitv_top: interrupt/trap collection, priority and vector selection
// assumes: core gives instruction boundary and stack done handshakes
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - nmi pending set by falling edge of its pin
// - nmi accepted regardless of mask bit
// - external request one and two active while pin held low
// - timer and serial causes merge into one internal request; here each keeps its own pend bit and vector
// - soft instruction serviced through vector FFFA
// - undefined opcode or address raises trap, vector FFEE
// - trap stacks registers then resumes at trap vector
// - undefined 0000-0027 expanded; 0000-003F and 0140-BFFF single chip
// - request one and strobe flag share vector FFF8
// - both compare channels share vector FFF4
// - fixed priority reset, trap, nmi, soft, down to serial
// - mode pins latched at reset pick mode and vector source
// - current instruction finishes before entry
// - entry stacks, sets mask, fetches vector, branches
// - after reset latch mode, set mask, load reset vector
module mitv_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  // pins
  input wire logic MODE_PIN_LOW,
  input wire logic MODE_PIN_HIGH,
  input wire logic NMI_N,
  input wire logic EXT_REQUEST_ONE_N,
  input wire logic EXT_REQUEST_TWO_N,
  // peripherals
  input wire logic PARALLEL_STROBE_FLAG,
  input wire logic CAPTURE_REQUEST,
  input wire logic [1:0] COMPARE_REQUEST,
  input wire logic OVERFLOW_REQUEST,
  input wire logic TIMER_TWO_MATCH_REQUEST,
  input wire logic SERIAL_REQUEST,
  // core
  input wire logic SOFT_INTERRUPT_INSTR,
  input wire logic UNDEF_OPCODE,
  input wire logic ACCESS_VALID,
  input wire logic [15:0] ACCESS_ADDR,
  input wire logic INSTR_BOUNDARY,
  input wire logic STACK_DONE,
  input wire logic MASK_CLEAR,
  // to core
  output logic STACK_REQ,
  output logic MASK_BIT,
  output logic VECTOR_VALID,
  output logic [15:0] VECTOR_ADDR,
  output logic VECTOR_EXTERNAL,
  output logic [1:0] MODE,
  output logic TRAP_FLAG
);
  typedef struct packed {
    mitv_pkg::mitv_state_e st;
    logic init;
    logic mask;
    logic [1:0] mode;
    logic vec_ext;
    logic [3:0] src;
    logic stack_req;
    logic vec_valid;
    logic [15:0] vec;
    logic trap_flag;
  } mitv_top_s;
  mitv_top_s s_reg, s_next;
  mitv_req_if req ();
  logic undef_addr;
  logic trap_event;
  logic [mitv_pkg::NSRC-1:0] enabled;
  logic [3:0] win;
  logic any;
  logic [mitv_pkg::NSRC-1:0] clr;

  // ==========================================================================
  // undefined address
  always_comb begin
    if (s_reg.mode == mitv_pkg::MODE_3) begin
      undef_addr = (ACCESS_ADDR <= mitv_pkg::UNDEF_SC_HI)
        || (ACCESS_ADDR >= mitv_pkg::UNDEF_SC2_LO && ACCESS_ADDR <= mitv_pkg::UNDEF_SC2_HI);
    end else begin
      undef_addr = ACCESS_ADDR <= mitv_pkg::UNDEF_EXP_HI;
    end
  end
  assign trap_event = UNDEF_OPCODE | (ACCESS_VALID & undef_addr);

  mitv_collect u_collect (
    .clock(CLOCK),
    .rstn(RSTN),
    .ce(CE),
    .nmi_n(NMI_N),
    .ext_request_one_n(EXT_REQUEST_ONE_N),
    .ext_request_two_n(EXT_REQUEST_TWO_N),
    .parallel_strobe_flag(PARALLEL_STROBE_FLAG),
    .soft_interrupt_instr(SOFT_INTERRUPT_INSTR),
    .trap_event(trap_event),
    .capture_request(CAPTURE_REQUEST),
    .compare_request(COMPARE_REQUEST),
    .overflow_request(OVERFLOW_REQUEST),
    .timer_two_match_request(TIMER_TWO_MATCH_REQUEST),
    .serial_request(SERIAL_REQUEST),
    .req(req.collector)
  );

  // ==========================================================================
  // priority
  // mask gating
  assign enabled = req.pend & (s_reg.mask ? mitv_pkg::NONMASKABLE : {mitv_pkg::NSRC{1'b1}});
  always_comb begin
    win = 4'h0;
    any = 1'b0;
    for (int i = mitv_pkg::NSRC - 1; i >= 0; i--) begin
      if (enabled[i]) begin
        win = 4'(i);
        any = 1'b1;
      end
    end
  end

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    unique case (s)
      mitv_pkg::SRC_RESET: vec_of = mitv_pkg::VEC_RESET;
      mitv_pkg::SRC_TRAP: vec_of = mitv_pkg::VEC_TRAP;
      mitv_pkg::SRC_NMI: vec_of = mitv_pkg::VEC_NMI;
      mitv_pkg::SRC_SOFT: vec_of = mitv_pkg::VEC_SOFT;
      mitv_pkg::SRC_REQ1: vec_of = mitv_pkg::VEC_REQ1;
      mitv_pkg::SRC_CAPTURE: vec_of = mitv_pkg::VEC_CAPTURE;
      mitv_pkg::SRC_COMPARE: vec_of = mitv_pkg::VEC_COMPARE;
      mitv_pkg::SRC_OVERFLOW: vec_of = mitv_pkg::VEC_OVERFLOW;
      mitv_pkg::SRC_T2MATCH: vec_of = mitv_pkg::VEC_T2MATCH;
      mitv_pkg::SRC_REQ2: vec_of = mitv_pkg::VEC_REQ2;
      mitv_pkg::SRC_SERIAL: vec_of = mitv_pkg::VEC_SERIAL;
      default: vec_of = mitv_pkg::VEC_RESET;
    endcase
  endfunction : vec_of

  // ==========================================================================
  // entry sequencer
  always_comb begin
    s_next = s_reg;
    clr = '0;
    if (MASK_CLEAR && s_reg.st == mitv_pkg::ST_RUN) s_next.mask = 1'b0;
    if (s_reg.vec_valid) s_next.vec_valid = 1'b0;
    unique case (s_reg.st)
      mitv_pkg::ST_RUN: begin
        if (s_reg.init) begin
          s_next.init = 1'b0;
          s_next.mode = {MODE_PIN_HIGH, MODE_PIN_LOW};
          s_next.vec_ext = {MODE_PIN_HIGH, MODE_PIN_LOW} == mitv_pkg::MODE_1;
          s_next.mask = 1'b1;
          s_next.src = mitv_pkg::SRC_RESET;
          s_next.st = mitv_pkg::ST_FETCH;
        end else if (INSTR_BOUNDARY && any) begin
          s_next.src = win;
          clr[win] = 1'b1;
          s_next.stack_req = 1'b1;
          s_next.st = mitv_pkg::ST_STACK;
        end
      end
      mitv_pkg::ST_STACK: begin
        if (STACK_DONE) begin
          s_next.stack_req = 1'b0;
          s_next.st = mitv_pkg::ST_MASK;
        end
      end
      mitv_pkg::ST_MASK: begin
        s_next.mask = 1'b1;
        if (s_reg.src == mitv_pkg::SRC_TRAP) s_next.trap_flag = 1'b0;
        s_next.st = mitv_pkg::ST_FETCH;
      end
      mitv_pkg::ST_FETCH: begin
        s_next.vec = vec_of(s_reg.src);
        s_next.vec_valid = 1'b1;
        s_next.st = mitv_pkg::ST_BRANCH;
      end
      mitv_pkg::ST_BRANCH: s_next.st = mitv_pkg::ST_RUN;
    endcase
    if (trap_event) s_next.trap_flag = 1'b1;
  end
  assign req.clr = clr;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_reg <= '{st: mitv_pkg::ST_RUN, init: 1'b1, mask: 1'b1, mode: mitv_pkg::MODE_3, vec_ext: 1'b0,
        src: mitv_pkg::SRC_RESET, stack_req: 1'b0, vec_valid: 1'b0, vec: 16'h0000,
        trap_flag: 1'b0};
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs
  assign STACK_REQ = s_reg.stack_req;
  assign MASK_BIT = s_reg.mask;
  assign VECTOR_VALID = s_reg.vec_valid;
  assign VECTOR_ADDR = s_reg.vec;
  assign VECTOR_EXTERNAL = s_reg.vec_ext;
  assign MODE = s_reg.mode;
  assign TRAP_FLAG = s_reg.trap_flag;

  mask_hold_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && s_reg.st == mitv_pkg::ST_RUN && !s_reg.init && s_reg.mask && INSTR_BOUNDARY && any
    |=> s_reg.src <= mitv_pkg::SRC_SOFT) else $error("masked source taken");
  boundary_entry_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && $rose(s_reg.stack_req) |-> $past(INSTR_BOUNDARY)) else $error("entry off boundary");
  mask_before_vec_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_reg.vec_valid |-> s_reg.mask) else $error("vector with mask clear");
  trap_vector_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    s_reg.vec_valid && s_reg.src == mitv_pkg::SRC_TRAP |-> s_reg.vec == mitv_pkg::VEC_TRAP)
    else $error("bad trap vector");
  priority_pick_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && s_reg.st == mitv_pkg::ST_RUN && !s_reg.init && INSTR_BOUNDARY && enabled[mitv_pkg::SRC_TRAP]
    |=> s_reg.src == mitv_pkg::SRC_TRAP) else $error("trap not highest");
  stack_then_vec_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
    CE && s_reg.st == mitv_pkg::ST_STACK && STACK_DONE |=> ##1 CE ##0 1'b1 ##1 s_reg.vec_valid || !CE)
    else $error("vector not after stack");
endmodule : mitv_top
`default_nettype wire

// File: testbench/mitv_core_model.sv
// mitv_core_model: core sequencer side, answers stack requests
// assumes: one clock, delay set by the bench
`timescale 1ns/1ns
`default_nettype none
module mitv_core_model (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // handshake
  input wire logic stack_req,
  input wire logic [3:0] delay,
  output logic stack_done
);
  // ==========================================================================
  // stacking
  logic [3:0] cnt_reg;
  logic busy_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'h0;
      stack_done <= 1'h0;
    end else begin
      stack_done <= 1'h0;
      if (!stack_req) begin
        busy_reg <= 1'h0;
      end else if (!busy_reg && cnt_reg == delay) begin
        stack_done <= 1'h1;
        busy_reg <= 1'h1;
        cnt_reg <= 4'h0;
      end else if (!busy_reg) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule : mitv_core_model
`default_nettype wire

// File: testbench/tb.sv
// tb: self-checking bench of the vectoring block
// assumes: core model answers stack requests, CE held high
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ==========================================================================
  // signals
  logic CLOCK, RSTN, MPL, MPH, NMI_N, EXT1_N, C0, IB;
  logic [6:0] lv;
  logic [3:0] pl, dly;
  logic [15:0] ADDR;
  logic SREQ, SDONE, MASK, VV, VEXT, TRAP;
  logic [15:0] VADDR;
  logic [1:0] MODE;
  int checks, miscompares;
  logic [15:0] tbl [7] = '{mitv_pkg::VEC_REQ1, mitv_pkg::VEC_CAPTURE, mitv_pkg::VEC_COMPARE,
    mitv_pkg::VEC_OVERFLOW, mitv_pkg::VEC_T2MATCH, mitv_pkg::VEC_REQ2, mitv_pkg::VEC_SERIAL};
  // ==========================================================================
  // design and core model
  mitv_top u_dut (.CLOCK(CLOCK), .RSTN(RSTN), .CE(1'h1), .MODE_PIN_LOW(MPL), .MODE_PIN_HIGH(MPH),
    .NMI_N(NMI_N), .EXT_REQUEST_ONE_N(EXT1_N), .EXT_REQUEST_TWO_N(~lv[5]),
    .PARALLEL_STROBE_FLAG(lv[0]), .CAPTURE_REQUEST(lv[1]), .COMPARE_REQUEST({lv[2], C0}),
    .OVERFLOW_REQUEST(lv[3]), .TIMER_TWO_MATCH_REQUEST(lv[4]), .SERIAL_REQUEST(lv[6]),
    .SOFT_INTERRUPT_INSTR(pl[2]), .UNDEF_OPCODE(pl[1]), .ACCESS_VALID(pl[0]), .ACCESS_ADDR(ADDR),
    .INSTR_BOUNDARY(IB), .STACK_DONE(SDONE), .MASK_CLEAR(pl[3]), .STACK_REQ(SREQ), .MASK_BIT(MASK),
    .VECTOR_VALID(VV), .VECTOR_ADDR(VADDR), .VECTOR_EXTERNAL(VEXT), .MODE(MODE), .TRAP_FLAG(TRAP));
  mitv_core_model u_core (.clock(CLOCK), .rstn(RSTN), .stack_req(SREQ), .delay(dly), .stack_done(SDONE));
  // ==========================================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic pulse(input logic [3:0] m);
    @(posedge CLOCK);
    pl <= m;
    @(posedge CLOCK);
    pl <= 4'h0;
    #1;
  endtask : pulse
  task automatic expect_vec(input logic [15:0] e);
    repeat (60) begin
      @(posedge CLOCK);
      #1;
      if (VV === 1'h1) break;
    end
    cmp("vector valid", 16'h1, {15'h0, VV});
    cmp("vector", e, VADDR);
    repeat (2) @(posedge CLOCK);
    #1;
  endtask : expect_vec
  task automatic expect_none(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      #1;
      cmp("stack request", 16'h0, {15'h0, SREQ});
    end
  endtask : expect_none
  task automatic do_reset(input logic lo, input logic hi, input logic [1:0] m);
    @(posedge CLOCK);
    RSTN <= 1'h0;
    MPL <= lo;
    MPH <= hi;
    repeat (3) @(posedge CLOCK);
    #1;
    cmp("mask", 16'h1, {15'h0, MASK});
    cmp("mode", 16'h3, {14'h0, MODE});
    @(posedge CLOCK);
    RSTN <= 1'h1;
    expect_vec(mitv_pkg::VEC_RESET);
    @(posedge CLOCK);
    MPL <= ~lo;
    MPH <= ~hi;
    repeat (2) @(posedge CLOCK);
    #1;
    cmp("mode", {14'h0, m}, {14'h0, MODE});
    cmp("vector source", {15'h0, m == mitv_pkg::MODE_1}, {15'h0, VEXT});
  endtask : do_reset
  task automatic probe(input logic [15:0] a, input logic t);
    @(posedge CLOCK);
    ADDR <= a;
    pulse(4'h1);
    cmp("trap flag", {15'h0, t}, {15'h0, TRAP});
    if (t) expect_vec(mitv_pkg::VEC_TRAP);
    else expect_none(8);
  endtask : probe
  // ==========================================================================
  // scenarios
  task automatic t_nmi();
    @(posedge CLOCK);
    IB <= 1'h0;
    NMI_N <= 1'h0;
    expect_none(5);
    @(posedge CLOCK);
    IB <= 1'h1;
    expect_vec(mitv_pkg::VEC_NMI);
    expect_none(8);
    @(posedge CLOCK);
    NMI_N <= 1'h1;
  endtask : t_nmi
  task automatic t_req_one();
    @(posedge CLOCK);
    EXT1_N <= 1'h0;
    expect_none(6);
    pulse(4'h8);
    cmp("mask", 16'h0, {15'h0, MASK});
    expect_vec(mitv_pkg::VEC_REQ1);
    cmp("mask", 16'h1, {15'h0, MASK});
    @(posedge CLOCK);
    EXT1_N <= 1'h1;
  endtask : t_req_one
  task automatic t_priority();
    @(posedge CLOCK);
    dly <= 4'h5;
    lv <= 7'h7F;
    pulse(4'h6);
    cmp("trap flag", 16'h1, {15'h0, TRAP});
    expect_vec(mitv_pkg::VEC_TRAP);
    cmp("trap flag", 16'h0, {15'h0, TRAP});
    expect_vec(mitv_pkg::VEC_SOFT);
    for (int i = 0; i < 7; i++) begin
      pulse(4'h8);
      expect_vec(tbl[i]);
      @(posedge CLOCK);
      lv <= lv & ~(7'h01 << i);
    end
    pulse(4'h8);
    expect_none(6);
    @(posedge CLOCK);
    C0 <= 1'h1;
    expect_vec(mitv_pkg::VEC_COMPARE);
    @(posedge CLOCK);
    C0 <= 1'h0;
    dly <= 4'h0;
  endtask : t_priority
  task automatic t_addr();
    probe(16'h0000, 1'h1);
    probe(16'h003F, 1'h1);
    probe(16'h0040, 1'h0);
    probe(16'h013F, 1'h0);
    probe(16'h0140, 1'h1);
    probe(16'hBFFF, 1'h1);
    probe(16'hC000, 1'h0);
    do_reset(1'h1, 1'h0, mitv_pkg::MODE_1);
    probe(16'h0027, 1'h1);
    probe(16'h0028, 1'h0);
    probe(16'h0140, 1'h0);
    do_reset(1'h0, 1'h1, mitv_pkg::MODE_2);
    probe(16'h0027, 1'h1);
    probe(16'h003F, 1'h0);
  endtask : t_addr
  // ==========================================================================
  // clock, watchdog, sequence
  initial begin
    CLOCK = 1'h0;
    forever #2 CLOCK = ~CLOCK;
  end
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  initial begin
    RSTN = 1'h0;
    {MPL, MPH, NMI_N, EXT1_N, IB} = 5'h1F;
    {C0, lv, pl, dly, ADDR} = 32'h0;
    do_reset(1'h1, 1'h1, mitv_pkg::MODE_3);
    t_nmi();
    t_req_one();
    t_priority();
    t_addr();
    close_out();
  end
endmodule : tb
`default_nettype wire
